// ### rtl/fppc_ctrl.sv
// Purpose: Flash program sequencer with protection and security
// Assumes: Array write port at 16-bit CPU address; single clock
// Notes: Register map is byte wide on a strobe port
`timescale 1ns/1ps
`default_nettype none
module fppc_ctrl
  import fppc_pkg::*;
#(
  parameter int PROG_CYC = FPPC_PROG_CYC,
  parameter int BURST_CYC = FPPC_BURST_CYC,
  parameter int HV_CYC = FPPC_HV_CYC,
  parameter logic [15:0] FLASH_TOP = 16'hFFFF
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // Array write port (CPU writes into flash space)
  input wire logic arr_write_i,
  input wire logic [15:0] arr_addr_i,
  input wire logic [7:0] arr_data_i,
  // Background debug and nonvolatile copy
  input wire logic bdm_prot_write_i,
  input wire logic [7:0] bdm_prot_data_i,
  input wire logic [7:0] nonvolatile_protection_byte_i,
  input wire logic blank_result_i,
  // Flash array side
  output logic pump_enable_o,
  output logic high_voltage_o,
  output logic prog_strobe_o,
  output logic [15:0] prog_addr_o,
  output logic [7:0] prog_data_o,
  output logic [7:0] prog_cmd_o,
  output logic unsecured_o
);

  // ----------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] flash_protection_q;
  logic prot_loaded_q;
  logic [1:0] sec_q;
  logic [7:0] key_q [8];
  logic [7:0] key_match_q [8];
  logic pviol_q;
  logic accerr_q;
  logic blank_q;
  logic cbeif_q;
  logic [15:0] q_addr_q;
  logic [7:0] q_data_q;
  logic [7:0] q_cmd_q;
  logic q_wr_q;
  logic q_pend_q;
  fppc_state_type state_q;
  logic [FPPC_CNT_W-1:0] cnt_q;
  logic [15:0] last_addr_q;
  logic burst_act_q;
  logic [7:0] cmd_q;
  logic [7:0] rdata_q;

  function automatic logic in_key(input logic [15:0] a);
    in_key = (a >= FPPC_KEY_BASE) && (a <= FPPC_KEY_LAST);
  endfunction : in_key

  function automatic logic is_prot(input logic [15:0] a, input logic [7:0] p);
    is_prot = !p[0] && (a > {p[7:1], 9'h1FF}) && (a <= FLASH_TOP);
  endfunction : is_prot

  logic wr_cfg;
  logic wr_prot;
  logic wr_sta;
  logic wr_cmd;
  logic key_mode;
  logic ccif;
  assign wr_cfg = reg_write_i && (reg_addr_i == FPPC_OFS_CONFIG);
  assign wr_prot = reg_write_i && (reg_addr_i == FPPC_OFS_PROT);
  assign wr_sta = reg_write_i && (reg_addr_i == FPPC_OFS_STATUS);
  assign wr_cmd = reg_write_i && (reg_addr_i == FPPC_OFS_COMMAND);
  assign key_mode = cfg_q[FPPC_CFG_KEYACC_BIT];
  // Complete only with nothing buffered or waiting
  assign ccif = (state_q == FPPC_IDLE) && cbeif_q && !q_pend_q;

  // ----------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------
  // upper bits stored, low bits dropped
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= FPPC_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata_i & FPPC_CFG_WMASK;
    end
  end

  // ----------------------------------------------------------
  // Protection register
  // ----------------------------------------------------------
  // load copy after reset release
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prot_loaded_q <= 1'b0;
      flash_protection_q <= 8'hFF;
    end else if (!prot_loaded_q) begin
      prot_loaded_q <= 1'b1;
      flash_protection_q <= nonvolatile_protection_byte_i;
    end else if (bdm_prot_write_i) begin
      flash_protection_q <= bdm_prot_data_i;
    end else if (wr_prot && !flash_protection_q[0] && reg_wdata_i[7:1] < flash_protection_q[7:1]) begin
      // only smaller select, enabled state only
      flash_protection_q <= {reg_wdata_i[7:1], 1'b0};
    end
  end

  // ----------------------------------------------------------
  // Key capture and security
  // ----------------------------------------------------------
  // key window writes captured in key mode
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        key_q[i] <= FPPC_KEY_RESET;
        key_match_q[i] <= FPPC_KEY_RESET;
      end
    end else if (arr_write_i && key_mode && in_key(arr_addr_i)) begin
      key_q[arr_addr_i[2:0]] <= arr_data_i;
    end
  end

  logic key_ok;
  always_comb begin
    // Last key byte compared as it arrives
    key_ok = (arr_data_i == key_match_q[7]);
    for (int i = 0; i < 7; i++) begin
      if (key_q[i] != key_match_q[i]) begin
        key_ok = 1'b0;
      end
    end
  end

  logic key_done;
  assign key_done = arr_write_i && key_mode && (arr_addr_i == FPPC_KEY_LAST);

  // unsecure on key match or blank pass
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sec_q <= FPPC_SEC_RESET;
    end else if ((key_done && key_ok) || (state_q == FPPC_DONE &&
        cmd_q == FPPC_CMD_BLANK && blank_result_i)) begin
      sec_q <= FPPC_SEC_UNSECURED;
    end
  end

  // ----------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------
  logic take_q;
  logic launch;
  logic start_try;
  logic refuse;
  logic go;
  assign take_q = arr_write_i && !key_mode && cbeif_q;
  assign launch = wr_sta && reg_wdata_i[FPPC_STA_CBEIF_BIT] && q_wr_q && !cbeif_q && !q_pend_q;
  // Launched command waits here until the sequencer is free
  assign start_try = q_pend_q && (state_q == FPPC_IDLE || state_q == FPPC_DONE);
  assign refuse = (launch || start_try) && is_prot(q_addr_q, flash_protection_q);
  assign go = start_try && !refuse;

  // array write captures address and data
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q_addr_q <= 16'h0000;
      q_data_q <= 8'h00;
      q_wr_q <= 1'b0;
      q_pend_q <= 1'b0;
      q_cmd_q <= 8'h00;
    end else begin
      if (take_q) begin
        q_addr_q <= arr_addr_i;
        q_data_q <= arr_data_i;
        q_wr_q <= 1'b1;
      end else if (refuse || go || (wr_sta && reg_wdata_i[FPPC_STA_ACCERR_BIT] && !q_pend_q)) begin
        // Buffer empties on hand-over, refusal or abort
        q_wr_q <= 1'b0;
      end
      if (launch && !refuse) begin
        q_pend_q <= 1'b1;
      end else if (refuse || go) begin
        q_pend_q <= 1'b0;
      end
      if (wr_cmd) begin
        q_cmd_q <= reg_wdata_i;
      end
    end
  end

  // status writes act: launch and flag clears

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cbeif_q <= 1'b1;
      pviol_q <= 1'b0;
      accerr_q <= 1'b0;
    end else begin
      if (take_q) begin
        cbeif_q <= 1'b0;
      end else if (refuse || go) begin
        cbeif_q <= 1'b1;
      end else if (wr_sta && reg_wdata_i[FPPC_STA_ACCERR_BIT] && !q_pend_q) begin
        cbeif_q <= 1'b1;
      end
      if (refuse) begin
        pviol_q <= 1'b1;
      end else if (wr_sta && reg_wdata_i[FPPC_STA_PVIOL_BIT]) begin
        pviol_q <= 1'b0;
      end
      if (wr_cmd && cbeif_q) begin
        accerr_q <= 1'b1;
      end else if (wr_sta && reg_wdata_i[FPPC_STA_ACCERR_BIT]) begin
        accerr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Program sequencer
  // ----------------------------------------------------------
  logic same_row_next;
  // next address must stay within row
  assign same_row_next = burst_act_q && (q_addr_q == last_addr_q + 16'h0001) &&
    (q_addr_q[FPPC_ROW_BITS-1:0] != 6'h00);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= FPPC_IDLE;
      cnt_q <= '0;
      last_addr_q <= 16'h0000;
      burst_act_q <= 1'b0;
      cmd_q <= 8'h00;
      high_voltage_o <= 1'b0;
      pump_enable_o <= 1'b0;
      prog_strobe_o <= 1'b0;
      prog_addr_o <= 16'h0000;
      prog_data_o <= 8'h00;
      prog_cmd_o <= 8'h00;
      blank_q <= 1'b0;
    end else begin
      prog_strobe_o <= 1'b0;
      unique case (state_q)
        FPPC_IDLE: begin
          if (go) begin
            cmd_q <= q_cmd_q;
            prog_addr_o <= q_addr_q;
            prog_data_o <= q_data_q;
            prog_cmd_o <= q_cmd_q;
            last_addr_q <= q_addr_q;
            pump_enable_o <= 1'b1;
            state_q <= FPPC_HVUP;
            cnt_q <= FPPC_CNT_W'(HV_CYC);
            burst_act_q <= (q_cmd_q == FPPC_CMD_BURST);
          end
        end
        FPPC_HVUP: begin
          high_voltage_o <= 1'b1;
          if (cnt_q <= 1) begin
            state_q <= FPPC_RUN;
            prog_strobe_o <= 1'b1;
            cnt_q <= FPPC_CNT_W'(PROG_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        FPPC_RUN: begin
          if (cnt_q <= 1) begin
            state_q <= FPPC_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        FPPC_DONE: begin
          if (cmd_q == FPPC_CMD_BLANK) begin
            blank_q <= blank_result_i;
          end
          if (go && q_cmd_q == FPPC_CMD_BURST && cmd_q == FPPC_CMD_BURST && same_row_next) begin
            // same row continues at burst time
            prog_addr_o <= q_addr_q;
            prog_data_o <= q_data_q;
            last_addr_q <= q_addr_q;
            prog_strobe_o <= 1'b1;
            state_q <= FPPC_RUN;
            cnt_q <= FPPC_CNT_W'(BURST_CYC);
          end else if (go) begin
            high_voltage_o <= 1'b0;
            cmd_q <= q_cmd_q;
            prog_addr_o <= q_addr_q;
            prog_data_o <= q_data_q;
            prog_cmd_o <= q_cmd_q;
            last_addr_q <= q_addr_q;
            burst_act_q <= (q_cmd_q == FPPC_CMD_BURST);
            state_q <= FPPC_HVUP;
            cnt_q <= FPPC_CNT_W'(HV_CYC);
          end else begin
            // nothing queued: pump and voltage off
            high_voltage_o <= 1'b0;
            pump_enable_o <= 1'b0;
            burst_act_q <= 1'b0;
            state_q <= FPPC_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Read path and security output
  // ----------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      unsecured_o <= 1'b0;
    end else begin
      unsecured_o <= (sec_q == FPPC_SEC_UNSECURED);
      rdata_q <= 8'h00;
      if (reg_read_i) begin
        unique case (reg_addr_i)
          FPPC_OFS_CONFIG: rdata_q <= cfg_q;
          FPPC_OFS_PROT: rdata_q <= flash_protection_q;
          FPPC_OFS_STATUS: rdata_q <= {cbeif_q, ccif, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};
          FPPC_OFS_COMMAND: rdata_q <= q_cmd_q;
          FPPC_OFS_SECURITY: rdata_q <= {6'h00, sec_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_cfg_low_zero: assert property (@(posedge clock_i) disable iff (rst_i) cfg_q[4:0] == 5'h00)
    else $error("config low bits not zero");
  a_prot_no_raise: assert property (@(posedge clock_i) disable iff (rst_i)
    (prot_loaded_q && !$past(bdm_prot_write_i) && $past(prot_loaded_q)) |-> flash_protection_q[7:1] <= $past(flash_protection_q[7:1]))
    else $error("protection select rose");
  a_prot_disabled: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_prot && flash_protection_q[0] && !bdm_prot_write_i && prot_loaded_q) |=> $stable(flash_protection_q))
    else $error("disabled protection changed");
  a_refuse_flag: assert property (@(posedge clock_i) disable iff (rst_i) refuse |=> pviol_q && cbeif_q)
    else $error("refusal not flagged");
  a_no_prot_go: assert property (@(posedge clock_i) disable iff (rst_i)
    go |-> !is_prot(q_addr_q, flash_protection_q))
    else $error("protected target launched");
  a_pump_off: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == FPPC_DONE && !go) |=> !pump_enable_o && !high_voltage_o)
    else $error("pump left on");
  a_key_no_cmd: assert property (@(posedge clock_i) disable iff (rst_i)
    (arr_write_i && key_mode && !q_wr_q) |=> !q_wr_q)
    else $error("key write queued command");
  a_sec_unsec: assert property (@(posedge clock_i) disable iff (rst_i)
    unsecured_o |-> $past(sec_q) == FPPC_SEC_UNSECURED)
    else $error("unsecured with wrong code");
  a_burst_time: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == FPPC_DONE && go && same_row_next && cmd_q == FPPC_CMD_BURST && q_cmd_q == FPPC_CMD_BURST)
    |=> cnt_q == FPPC_CNT_W'(BURST_CYC))
    else $error("burst byte not short time");
endmodule : fppc_ctrl
`default_nettype wire

// ### rtl/fppc_pkg.sv
// Purpose: Constants for the flash program and protection controller
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Timing counts scale with the clock rate
// Function
// - Flash rows hold 64 bytes; address bits 5..0 pick the byte.
// - Address with bits 5..0 all zero starts a new row.
// - First burst byte takes the standard program time.
// - Next address in the same row programs in the short burst time.
// - Burst crossing into a new row drops and restores high voltage, standard time.
// - No queued command of any kind at completion switches the pump and high voltage off.
// - Only security field 1:0 is unsecured; key match or blank check sets it.
// - Configuration bits 7..5 read and write at any time.
// - Configuration bits 4..0 read zero and ignore writes.
// - Key-access bit 0: writes to FFB0..FFB7 start a flash command.
// - Key-access bit 1: key window writes are captured as key bytes.
// - Protection register loads from the nonvolatile byte at reset, always readable.
// - With protection enabled, only a smaller protect-select value is accepted.
// - With protection disabled, writes leave protection unchanged.
// - Protect-select bits 7:1 set end of unprotected region; protected part is high.
// - Program or erase inside the protected region is refused.
// - Protection-disable at bit 0: 0 protects selected block, 1 protects nothing.
// - Background debug writes change protection without the increase-only limit.
// - Status bits 3, 1, 0 read zero and ignore writes.
// - Other five status bits readable; writes to bits 7, 5, 4 act, not store; writes to bits 6, 2 do nothing.
package fppc_pkg;
  // Register offsets
  localparam logic [2:0] FPPC_OFS_CONFIG = 3'h0;
  localparam logic [2:0] FPPC_OFS_PROT = 3'h1;
  localparam logic [2:0] FPPC_OFS_STATUS = 3'h2;
  localparam logic [2:0] FPPC_OFS_COMMAND = 3'h3;
  localparam logic [2:0] FPPC_OFS_SECURITY = 3'h4;
  // Field positions
  localparam int FPPC_CFG_KEYACC_BIT = 5;
  localparam int FPPC_STA_CBEIF_BIT = 7;
  localparam int FPPC_STA_CCIF_BIT = 6;
  localparam int FPPC_STA_PVIOL_BIT = 5;
  localparam int FPPC_STA_ACCERR_BIT = 4;
  localparam int FPPC_STA_BLANK_BIT = 2;
  // Masks and reset values
  localparam logic [7:0] FPPC_CFG_WMASK = 8'hE0;
  localparam logic [7:0] FPPC_CFG_RESET = 8'h00;
  localparam logic [1:0] FPPC_SEC_UNSECURED = 2'h2;
  localparam logic [1:0] FPPC_SEC_RESET = 2'h3;
  localparam logic [7:0] FPPC_KEY_RESET = 8'h00;
  // Key window and row
  localparam logic [15:0] FPPC_KEY_BASE = 16'hFFB0;
  localparam logic [15:0] FPPC_KEY_LAST = 16'hFFB7;
  localparam int FPPC_ROW_BITS = 6;
  // Commands
  localparam logic [7:0] FPPC_CMD_BLANK = 8'h05;
  localparam logic [7:0] FPPC_CMD_BYTE = 8'h20;
  localparam logic [7:0] FPPC_CMD_BURST = 8'h25;
  localparam logic [7:0] FPPC_CMD_PAGE = 8'h40;
  localparam logic [7:0] FPPC_CMD_MASS = 8'h41;
  // Timing
  localparam int FPPC_CLK_MHZ = 200;
  localparam int FPPC_T_PROG_NS = 45000;
  localparam int FPPC_T_BURST_NS = 20000;
  localparam int FPPC_T_HV_NS = 5000;
  localparam int FPPC_PROG_CYC = FPPC_T_PROG_NS * FPPC_CLK_MHZ / 1000;
  localparam int FPPC_BURST_CYC = FPPC_T_BURST_NS * FPPC_CLK_MHZ / 1000;
  localparam int FPPC_HV_CYC = FPPC_T_HV_NS * FPPC_CLK_MHZ / 1000;
  localparam int FPPC_CNT_W = 20;
  // Sequencer states
  typedef enum logic [3:0] {
    FPPC_IDLE = 4'b0001,
    FPPC_HVUP = 4'b0010,
    FPPC_RUN = 4'b0100,
    FPPC_DONE = 4'b1000
  } fppc_state_type;
endpackage : fppc_pkg

// ### tb/fppc_ctrl_test.sv
// Purpose: Self-checking bench for the flash program and protection controller
// Assumes: Short program times set through parameters
// Notes: Blank check runs before any byte is programmed; second reset mid-run
`timescale 1ns/1ps
`default_nettype none
module fppc_ctrl_test;
  import fppc_pkg::*;
  localparam int PROG = 24;
  localparam int BURST = 10;
  localparam int HV = 3;
  logic clock_i, rst_i, reg_write_i, reg_read_i, arr_write_i, bdm_prot_write_i, blank_result_i;
  logic pump_enable_o, high_voltage_o, prog_strobe_o, unsecured_o, pump_p, hv_p;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, arr_data_i, bdm_prot_data_i, nv_byte, prog_data_o, prog_cmd_o, peek_data, v;
  logic [15:0] arr_addr_i, prog_addr_o, peek_addr;
  int n_errors = 0, checks = 0, cyc = 0, strobes = 0, hv_falls = 0, last_strobe = 0, pump_off = 0, m_std, t, f;
  fppc_ctrl #(.PROG_CYC(PROG), .BURST_CYC(BURST), .HV_CYC(HV), .FLASH_TOP(16'hFFFF)) fppc_ctrl_inst (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .arr_write_i(arr_write_i), .arr_addr_i(arr_addr_i), .arr_data_i(arr_data_i),
    .bdm_prot_write_i(bdm_prot_write_i), .bdm_prot_data_i(bdm_prot_data_i),
    .nonvolatile_protection_byte_i(nv_byte), .blank_result_i(blank_result_i),
    .pump_enable_o(pump_enable_o), .high_voltage_o(high_voltage_o), .prog_strobe_o(prog_strobe_o),
    .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o), .prog_cmd_o(prog_cmd_o), .unsecured_o(unsecured_o));
  fppc_flash_model fppc_flash_model_inst (
    .clock_i(clock_i), .high_voltage_i(high_voltage_o), .prog_strobe_i(prog_strobe_o),
    .prog_addr_i(prog_addr_o), .prog_data_i(prog_data_o), .prog_cmd_i(prog_cmd_o),
    .blank_result_o(blank_result_i), .peek_addr_i(peek_addr), .peek_data_o(peek_data));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // ----------------------------------------
  // Monitor, timeout and checking
  // ----------------------------------------
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    pump_p <= pump_enable_o;
    hv_p <= high_voltage_o;
    if (prog_strobe_o === 1'b1) begin
      strobes <= strobes + 1;
      last_strobe <= cyc;
    end
    if (pump_p === 1'b1 && pump_enable_o === 1'b0) pump_off <= cyc;
    if (hv_p === 1'b1 && high_voltage_o === 1'b0) hv_falls <= hv_falls + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      results();
    end
  end
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_reg(n, {7'h00, e}, {7'h00, g});
  endtask : chk_pin
  task automatic chk_num(input string n, input int e, input int g);
    checks++;
    if (g != e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_num
  task automatic results();
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic aw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    arr_addr_i <= a;
    arr_data_i <= d;
    arr_write_i <= 1'b1;
    @(posedge clock_i);
    arr_write_i <= 1'b0;
  endtask : aw
  task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    aw(a, d);
    wr(FPPC_OFS_COMMAND, c);
    wr(FPPC_OFS_STATUS, 8'h80);
  endtask : prog
  task automatic wait_status(input int b);
    logic [7:0] s;
    int i;
    for (i = 0; i < 300; i++) begin
      rd(FPPC_OFS_STATUS, s);
      if (s[b] === 1'b1 && s[FPPC_STA_CBEIF_BIT] === 1'b1 && (b != FPPC_STA_CCIF_BIT || pump_enable_o === 1'b0)) break;
    end
    chk_num("status wait bound", 1, int'(i < 300));
    repeat (2) @(posedge clock_i);
  endtask : wait_status
  task automatic chk_mem(input logic [15:0] a, input logic [7:0] e);
    peek_addr = a;
    #1 chk_reg("flash byte", e, peek_data);
  endtask : chk_mem
  task automatic burst_pair(input logic [15:0] a, output int tm, output int fl);
    int f0;
    f0 = hv_falls;
    prog(a, 8'h5A, FPPC_CMD_BURST);
    wait_status(FPPC_STA_CBEIF_BIT);
    prog(a + 16'h0001, 8'hC3, FPPC_CMD_BURST);
    wait_status(FPPC_STA_CCIF_BIT);
    tm = pump_off - last_strobe;
    fl = hv_falls - f0;
    chk_mem(a, 8'h5A);
    chk_mem(a + 16'h0001, 8'hC3);
  endtask : burst_pair
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset(input logic [7:0] nv);
    @(posedge clock_i);
    nv_byte <= nv;
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rd(FPPC_OFS_PROT, v);
    chk_reg("protection after reset", nv, v);
    rd(FPPC_OFS_CONFIG, v);
    chk_reg("config after reset", FPPC_CFG_RESET, v);
    rd(FPPC_OFS_SECURITY, v);
    chk_reg("security after reset", {6'h00, FPPC_SEC_RESET}, {6'h00, v[1:0]});
    chk_pin("unsecured after reset", 1'b0, unsecured_o);
  endtask : t_reset
  task automatic t_regs();
    wr(FPPC_OFS_CONFIG, 8'hFF);
    rd(FPPC_OFS_CONFIG, v);
    chk_reg("config all ones", FPPC_CFG_WMASK, v);
    wr(FPPC_OFS_CONFIG, 8'h00);
    rd(FPPC_OFS_CONFIG, v);
    chk_reg("config cleared", 8'h00, v);
    wr(FPPC_OFS_STATUS, 8'h0B);
    rd(FPPC_OFS_STATUS, v);
    chk_reg("status fixed bits", 8'h00, v & 8'h0B);
    wr(FPPC_OFS_COMMAND, FPPC_CMD_BYTE);
    rd(FPPC_OFS_STATUS, v);
    chk_pin("access error set", 1'b1, v[FPPC_STA_ACCERR_BIT]);
    wr(FPPC_OFS_STATUS, 8'h10);
    rd(FPPC_OFS_STATUS, v);
    chk_pin("access error cleared", 1'b0, v[FPPC_STA_ACCERR_BIT]);
  endtask : t_regs
  task automatic t_blank();
    prog(16'h1000, 8'hFF, FPPC_CMD_BLANK);
    wait_status(FPPC_STA_CCIF_BIT);
    chk_pin("unsecured after blank", 1'b1, unsecured_o);
    rd(FPPC_OFS_STATUS, v);
    chk_pin("blank status", 1'b1, v[FPPC_STA_BLANK_BIT]);
    rd(FPPC_OFS_SECURITY, v);
    chk_reg("security after blank", {6'h00, FPPC_SEC_UNSECURED}, {6'h00, v[1:0]});
  endtask : t_blank
  task automatic t_key();
    int s0;
    s0 = strobes;
    wr(FPPC_OFS_CONFIG, 8'h20);
    for (int i = 0; i < 8; i++) aw(FPPC_KEY_BASE + 16'(i), FPPC_KEY_RESET);
    repeat (4) @(posedge clock_i);
    chk_pin("unsecured after key", 1'b1, unsecured_o);
    chk_num("strobes in key mode", 0, strobes - s0);
    chk_mem(FPPC_KEY_BASE, 8'hFF);
    wr(FPPC_OFS_CONFIG, 8'h00);
  endtask : t_key
  task automatic t_protect();
    int s0;
    s0 = strobes;
    prog(16'hA200, 8'h11, FPPC_CMD_BYTE);
    wait_status(FPPC_STA_CCIF_BIT);
    rd(FPPC_OFS_STATUS, v);
    chk_pin("violation set", 1'b1, v[FPPC_STA_PVIOL_BIT]);
    chk_num("refused strobes", 0, strobes - s0);
    chk_mem(16'hA200, 8'hFF);
    wr(FPPC_OFS_STATUS, 8'h20);
    rd(FPPC_OFS_STATUS, v);
    chk_pin("violation cleared", 1'b0, v[FPPC_STA_PVIOL_BIT]);
    prog(16'hA1FF, 8'h3C, FPPC_CMD_BYTE);
    wait_status(FPPC_STA_CCIF_BIT);
    chk_mem(16'hA1FF, 8'h3C);
    wr(FPPC_OFS_PROT, 8'hC0);
    rd(FPPC_OFS_PROT, v);
    chk_reg("protection decrease", 8'hA0, v);
    wr(FPPC_OFS_PROT, 8'h80);
    rd(FPPC_OFS_PROT, v);
    chk_reg("protection increase", 8'h80, v);
    @(posedge clock_i);
    bdm_prot_data_i <= 8'hC1;
    bdm_prot_write_i <= 1'b1;
    @(posedge clock_i);
    bdm_prot_write_i <= 1'b0;
    rd(FPPC_OFS_PROT, v);
    chk_reg("debug protection write", 8'hC1, v);
    wr(FPPC_OFS_PROT, 8'h00);
    rd(FPPC_OFS_PROT, v);
    chk_reg("protection while disabled", 8'hC1, v);
    prog(FPPC_KEY_BASE, 8'h5A, FPPC_CMD_BYTE);
    wait_status(FPPC_STA_CCIF_BIT);
    chk_mem(FPPC_KEY_BASE, 8'h5A);
  endtask : t_protect
  task automatic t_timing();
    prog(16'h1000, 8'hA5, FPPC_CMD_BYTE);
    wait_status(FPPC_STA_CCIF_BIT);
    m_std = pump_off - last_strobe;
    chk_num("standard time floor", 1, int'(m_std >= PROG));
    chk_mem(16'h1000, 8'hA5);
    prog(16'h1002, 8'h0F, FPPC_CMD_BURST);
    wait_status(FPPC_STA_CCIF_BIT);
    chk_num("first burst byte time", m_std, pump_off - last_strobe);
    burst_pair(16'h1010, t, f);
    chk_num("same row burst time", m_std - (PROG - BURST), t);
    chk_num("same row voltage drops", 1, f);
    burst_pair(16'h103F, t, f);
    chk_num("new row burst time", m_std, t);
    chk_num("new row voltage drops", 2, f);
    chk_pin("pump off after burst", 1'b0, pump_enable_o);
    chk_pin("voltage off after burst", 1'b0, high_voltage_o);
  endtask : t_timing
  initial begin
    rst_i = 1'b1;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    arr_write_i = 1'b0;
    arr_addr_i = 16'h0000;
    arr_data_i = 8'h00;
    bdm_prot_write_i = 1'b0;
    bdm_prot_data_i = 8'h00;
    nv_byte = 8'hFF;
    peek_addr = 16'h0000;
    t_reset(8'hFF);
    t_regs();
    t_blank();
    t_reset(8'hA0);
    t_key();
    t_protect();
    t_timing();
    results();
  end
endmodule : fppc_ctrl_test
`default_nettype wire

// ### tb/fppc_flash_model.sv
// Purpose: Behavioural flash array behind the sequencer
// Assumes: Cells only program while high voltage is applied
// Notes: Contents survive reset like real nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
module fppc_flash_model
  import fppc_pkg::*;
(
  // Sequencer side
  input wire logic clock_i,
  input wire logic high_voltage_i,
  input wire logic prog_strobe_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic [7:0] prog_cmd_i,
  output logic blank_result_o,
  // Bench peek port
  input wire logic [15:0] peek_addr_i,
  output logic [7:0] peek_data_o
);
  logic [7:0] mem_q [0:65535];
  logic blank_q;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_q[i] = 8'hFF;
    end
    blank_q = 1'b1;
  end
  // Programming only clears bits, and only with high voltage up
  always @(posedge clock_i) begin
    if (prog_strobe_i && high_voltage_i && (prog_cmd_i == FPPC_CMD_BYTE || prog_cmd_i == FPPC_CMD_BURST)) begin
      mem_q[prog_addr_i] <= mem_q[prog_addr_i] & prog_data_i;
      blank_q <= 1'b0;
    end
  end
  assign blank_result_o = blank_q;
  assign peek_data_o = mem_q[peek_addr_i];
endmodule : fppc_flash_model
`default_nettype wire
